// File: scf_pkg.sv
// Purpose: Shared constants and types for the serial status flag block
// Assumes: 8-bit register bus, flags and control on one clock
// Notes:   Offsets are byte addresses on the plain register port
//
// Behaviour
// - Buffer-empty flag sets at reset and when a word enters the shifter.
// - Buffer-empty clears by status read seeing it set, then data write.
// - Done flag sets at reset and when buffer empty and nothing shifts.
// - Done clears by status read, then data write, enable rise or break.
// - Buffer-full flag sets when a character enters the data register.
// - Buffer-full clears by status read seeing it set, then data read.
// - Idle flag sets after 10 high bit times, 11 in nine-bit mode.
// - Idle select 0: counting starts right after the start bit.
// - Idle select 1: counting starts only after the stop bit.
// - Idle clears by status read and data read; rearms only after new character.
// - Overrun sets when a character arrives unread; new character is dropped.
// - Overrun clears by status read seeing it set, then data read.
// - Seven start samples, three per bit; disagreement sets noise flag.
// - Noise flag clears by status read, then data read.
// - Stop bit sampled low sets stop-bit error with buffer-full.
// - Stop-bit error clears by status read seeing it set, then data read.
// - Parity mismatch sets parity error with buffer-full when enabled.
// - Parity error clears by status read, then data read.
// - Status register is read-only; writes do nothing.
// - Parity uses the character MSB; select 0 even, 1 odd.

package scf_pkg;

   // ****************************************************
   // Register map
   // ****************************************************
   localparam int unsigned SCF_ADDR_W        = 8;
   localparam logic [7:0]  SCF_OFS_CTRL_ONE  = 8'h00;
   localparam logic [7:0]  SCF_OFS_CTRL_TWO  = 8'h01;
   localparam logic [7:0]  SCF_OFS_STATUS    = 8'h02;
   localparam logic [7:0]  SCF_OFS_DATA      = 8'h03;

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int unsigned SCF_POS_TX_BUFFER_EMPTY = 7;
   localparam int unsigned SCF_POS_TX_DONE         = 6;
   localparam int unsigned SCF_POS_RX_BUFFER_FULL  = 5;
   localparam int unsigned SCF_POS_IDLE            = 4;
   localparam int unsigned SCF_POS_OVERRUN         = 3;
   localparam int unsigned SCF_POS_NOISE_SEEN      = 2;
   localparam int unsigned SCF_POS_STOP_BIT_ERROR  = 1;
   localparam int unsigned SCF_POS_PARITY_ERROR    = 0;
   localparam int unsigned SCF_POS_NINE_BIT_MODE   = 4;
   localparam int unsigned SCF_POS_IDLE_COUNT_SEL  = 2;
   localparam int unsigned SCF_POS_PARITY_ON       = 1;
   localparam int unsigned SCF_POS_PARITY_ODD      = 0;
   localparam int unsigned SCF_POS_TX_ON           = 3;
   localparam int unsigned SCF_POS_BREAK_QUEUE     = 0;

   // ****************************************************
   // Reset values and counts
   // ****************************************************
   localparam logic [7:0]  SCF_STATUS_RST    = 8'hC0;
   localparam logic [7:0]  SCF_CTRL_ONE_MASK = 8'h17;
   localparam logic [7:0]  SCF_CTRL_RST      = 8'h00;
   localparam logic [3:0]  SCF_IDLE_BITS     = 4'hA;
   localparam logic [3:0]  SCF_IDLE_BITS_M   = 4'hB;
   localparam int unsigned SCF_START_SAMPLES = 7;
   localparam int unsigned SCF_BIT_SAMPLES   = 3;

   typedef enum logic [1:0]
   {
      SCF_BIT_IDLE  = 2'b00,
      SCF_BIT_START = 2'b01,
      SCF_BIT_DATA  = 2'b11,
      SCF_BIT_STOP  = 2'b10
   } scf_bit_kind_type;

   typedef struct packed
   {
      scf_bit_kind_type kind;
      logic [6:0]       samples;
   } scf_rx_bit_type;

   typedef struct packed
   {
      logic [SCF_ADDR_W-1:0] addr;
      logic [7:0]            wdata;
      logic                  wr;
      logic                  rd;
   } scf_bus_req_type;

endpackage : scf_pkg

// File: scf_status_flags.sv
// Purpose: Status flags of an asynchronous serial port and their clear sequences
// Assumes: Shifters and baud logic on the same clock report events to this block
// Notes:   Each flag clears only after a status read saw it set, then the data access, or for done an enable rise or break
//
// Our own choices: the address map and strobed register access.

`timescale 1ns/10ps

module scf_status_flags #(
   parameter int unsigned IDLE_CNT_W = 4
) (
   input  wire logic                     clk_i,            // 20 MHz clock
   input  wire logic                     rst_b_i,          // Async reset, active low
   input  wire logic                     ce_i,             // Clock enable, freezes all state
   input  wire scf_pkg::scf_bus_req_type bus_i,            // Register request
   output logic [7:0]                    rd_data_o,        // Read data, cycle after strobe
   input  wire logic                     tx_load_i,        // Buffer word moved into shifter
   input  wire logic                     tx_busy_i,        // Data, preamble or break shifting
   input  wire logic                     rx_bit_valid_i,   // One bit time finished
   input  wire scf_pkg::scf_rx_bit_type  rx_bit_i,         // Kind and samples of that bit
   output logic [7:0]                    tx_data_o,        // Transmit buffer word
   output logic                          tx_buffer_empty_o,// Buffer free for a new word
   output logic                          tx_on_o,          // Transmitter enable
   output logic                          break_queue_o,    // Break queue request
   output logic                          preamble_req_o,   // Pulse: enable rose, queue preamble
   output logic [7:0]                    rx_data_o,        // Receive data register
   output logic                          rx_ninth_o        // Ninth received bit
);

   // ****************************************************
   // Parameter check
   // ****************************************************
   if (IDLE_CNT_W < 4)
   begin : g_bad_width
      $error("IDLE_CNT_W must hold a count of eleven");
   end

   // ****************************************************
   // Register decode
   // ****************************************************
   logic                  stat_rd;
   logic                  data_rd;
   logic                  data_wr;
   logic                  ctl1_wr;
   logic                  ctl2_wr;
   logic                  te_rise;
   logic                  brk_wr;
   logic [7:0]            ctrl_one;
   logic [7:0]            flag;
   logic [7:0]            arm;
   logic [7:0]            set_v;
   logic [7:0]            done_v;
   logic [7:0]            clr_v;
   logic [7:0]            next_rd_data;

   assign stat_rd = bus_i.rd && (bus_i.addr == scf_pkg::SCF_OFS_STATUS);
   assign data_rd = bus_i.rd && (bus_i.addr == scf_pkg::SCF_OFS_DATA);
   assign data_wr = bus_i.wr && (bus_i.addr == scf_pkg::SCF_OFS_DATA);
   assign ctl1_wr = bus_i.wr && (bus_i.addr == scf_pkg::SCF_OFS_CTRL_ONE);
   assign ctl2_wr = bus_i.wr && (bus_i.addr == scf_pkg::SCF_OFS_CTRL_TWO);
   assign te_rise = ctl2_wr && bus_i.wdata[scf_pkg::SCF_POS_TX_ON] && !tx_on_o;
   assign brk_wr  = ctl2_wr && bus_i.wdata[scf_pkg::SCF_POS_BREAK_QUEUE];

   always_comb
   begin
      next_rd_data = 8'h00;
      unique case (bus_i.addr)
         scf_pkg::SCF_OFS_CTRL_ONE: next_rd_data = ctrl_one;
         scf_pkg::SCF_OFS_CTRL_TWO:
         begin
            next_rd_data[scf_pkg::SCF_POS_TX_ON]       = tx_on_o;
            next_rd_data[scf_pkg::SCF_POS_BREAK_QUEUE] = break_queue_o;
         end
         scf_pkg::SCF_OFS_STATUS:   next_rd_data = flag;
         scf_pkg::SCF_OFS_DATA:     next_rd_data = rx_data_o;
         default:                   next_rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rd_data_o <= 8'h00;
      else if (ce_i && bus_i.rd)
         rd_data_o <= next_rd_data;
   end

   // ****************************************************
   // Control registers
   // ****************************************************
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         ctrl_one <= scf_pkg::SCF_CTRL_RST;
      else if (ce_i && ctl1_wr)
         ctrl_one <= bus_i.wdata & scf_pkg::SCF_CTRL_ONE_MASK;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         tx_on_o        <= 1'b0;
         break_queue_o  <= 1'b0;
         preamble_req_o <= 1'b0;
      end
      else if (ce_i)
      begin
         preamble_req_o <= te_rise;
         if (ctl2_wr)
         begin
            tx_on_o       <= bus_i.wdata[scf_pkg::SCF_POS_TX_ON];
            break_queue_o <= bus_i.wdata[scf_pkg::SCF_POS_BREAK_QUEUE];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         tx_data_o <= 8'h00;
      else if (ce_i && data_wr)
         tx_data_o <= bus_i.wdata;
   end

   // ****************************************************
   // Receive bit evaluation
   // ****************************************************
   function automatic logic scf_maj3(input logic [2:0] s);
      return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : scf_maj3

   logic                  start_tick;
   logic                  data_tick;
   logic                  stop_tick;
   logic                  idle_tick;
   logic                  bit_level;
   logic                  bit_noisy;
   logic                  noise_acc;
   logic                  parity_acc;
   logic [8:0]            shreg;
   logic                  frame_noise;
   logic                  stop_bad;
   logic                  parity_bad;
   logic                  char_load;
   logic                  overrun_set;
   logic [6:0]            start_s;
   logic [2:0]            bit_s;

   assign start_s    = rx_bit_i.samples[scf_pkg::SCF_START_SAMPLES-1:0];
   assign bit_s      = rx_bit_i.samples[scf_pkg::SCF_BIT_SAMPLES-1:0];
   assign start_tick = rx_bit_valid_i && (rx_bit_i.kind == scf_pkg::SCF_BIT_START);
   assign data_tick  = rx_bit_valid_i && (rx_bit_i.kind == scf_pkg::SCF_BIT_DATA);
   assign stop_tick  = rx_bit_valid_i && (rx_bit_i.kind == scf_pkg::SCF_BIT_STOP);
   assign idle_tick  = rx_bit_valid_i && (rx_bit_i.kind == scf_pkg::SCF_BIT_IDLE);
   assign bit_level  = scf_maj3(bit_s);
   // Any disagreeing sample within one bit time
   assign bit_noisy  = (rx_bit_i.kind == scf_pkg::SCF_BIT_START) ?
                       !((&start_s) || !(|start_s)) : !((&bit_s) || !(|bit_s));
   assign frame_noise = noise_acc || bit_noisy;
   assign stop_bad    = !bit_level;
   // MSB of the character is the parity bit and is already in the sum
   assign parity_bad  = ctrl_one[scf_pkg::SCF_POS_PARITY_ON] &&
                        (parity_acc ^ ctrl_one[scf_pkg::SCF_POS_PARITY_ODD]);

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         noise_acc  <= 1'b0;
         parity_acc <= 1'b0;
         shreg      <= 9'h000;
      end
      else if (ce_i)
      begin
         if (start_tick)
         begin
            noise_acc  <= bit_noisy;
            parity_acc <= 1'b0;
            shreg      <= 9'h000;
         end
         else if (data_tick)
         begin
            noise_acc  <= frame_noise;
            parity_acc <= parity_acc ^ bit_level;
            shreg      <= {bit_level, shreg[8:1]};
         end
      end
   end

   // Unread character blocks the transfer; the new one is dropped
   assign char_load   = stop_tick && !(flag[scf_pkg::SCF_POS_RX_BUFFER_FULL] &&
                        !clr_v[scf_pkg::SCF_POS_RX_BUFFER_FULL]);
   assign overrun_set = stop_tick && !char_load;

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rx_data_o  <= 8'h00;
         rx_ninth_o <= 1'b0;
      end
      else if (ce_i && char_load)
      begin
         rx_data_o  <= ctrl_one[scf_pkg::SCF_POS_NINE_BIT_MODE] ? shreg[7:0] : shreg[8:1];
         rx_ninth_o <= ctrl_one[scf_pkg::SCF_POS_NINE_BIT_MODE] & shreg[8];
      end
   end

   // ****************************************************
   // Idle line detection
   // ****************************************************
   logic [IDLE_CNT_W-1:0] idle_cnt;
   logic [IDLE_CNT_W-1:0] idle_thr;
   logic [IDLE_CNT_W-1:0] cnt_up;
   logic                  count_on;
   logic                  idle_allow;
   logic                  idle_set;

   assign idle_thr = ctrl_one[scf_pkg::SCF_POS_NINE_BIT_MODE] ?
                     IDLE_CNT_W'(scf_pkg::SCF_IDLE_BITS_M) : IDLE_CNT_W'(scf_pkg::SCF_IDLE_BITS);
   assign cnt_up   = (idle_cnt < idle_thr) ? idle_cnt + 1'b1 : idle_cnt;
   assign idle_set = idle_allow && (idle_cnt >= idle_thr);

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         idle_cnt <= '0;
         count_on <= 1'b0;
      end
      else if (ce_i)
      begin
         if (start_tick)
         begin
            idle_cnt <= '0;
            count_on <= !ctrl_one[scf_pkg::SCF_POS_IDLE_COUNT_SEL];
         end
         else if (stop_tick && ctrl_one[scf_pkg::SCF_POS_IDLE_COUNT_SEL])
         begin
            idle_cnt <= '0;
            count_on <= 1'b1;
         end
         else if ((data_tick || stop_tick || idle_tick) && count_on)
            idle_cnt <= bit_level ? cnt_up : '0;
      end
   end

   // Rearmed only by a new character, so idle sets once per gap
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         idle_allow <= 1'b0;
      else if (ce_i)
      begin
         if (char_load)
            idle_allow <= 1'b1;
         else if (idle_set)
            idle_allow <= 1'b0;
      end
   end

   // ****************************************************
   // Flag set and clear
   // ****************************************************
   logic                  tc_cond;
   logic                  tc_cond_q;

   assign tc_cond = flag[scf_pkg::SCF_POS_TX_BUFFER_EMPTY] && !tx_busy_i;

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         tc_cond_q <= 1'b1;
      else if (ce_i)
         tc_cond_q <= tc_cond;
   end

   always_comb
   begin
      set_v = 8'h00;
      set_v[scf_pkg::SCF_POS_TX_BUFFER_EMPTY] = tx_load_i;
      set_v[scf_pkg::SCF_POS_TX_DONE]         = tc_cond && !tc_cond_q;
      set_v[scf_pkg::SCF_POS_RX_BUFFER_FULL]  = char_load;
      set_v[scf_pkg::SCF_POS_IDLE]            = idle_set;
      set_v[scf_pkg::SCF_POS_OVERRUN]         = overrun_set;
      set_v[scf_pkg::SCF_POS_NOISE_SEEN]      = char_load && frame_noise;
      set_v[scf_pkg::SCF_POS_STOP_BIT_ERROR]  = char_load && stop_bad;
      set_v[scf_pkg::SCF_POS_PARITY_ERROR]    = char_load && parity_bad;
   end

   always_comb
   begin
      done_v = {8{data_rd}};
      done_v[scf_pkg::SCF_POS_TX_BUFFER_EMPTY] = data_wr;
      done_v[scf_pkg::SCF_POS_TX_DONE]         = data_wr || te_rise || brk_wr;
   end

   assign clr_v = arm & done_v;

   // Set beats clear; a set after the status read disarms the clear
   for (genvar i = 0; i < 8; i++)
   begin : g_flag
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
         if (!rst_b_i)
         begin
            flag[i] <= scf_pkg::SCF_STATUS_RST[i];
            arm[i]  <= 1'b0;
         end
         else if (ce_i)
         begin
            if (set_v[i])
               flag[i] <= 1'b1;
            else if (clr_v[i])
               flag[i] <= 1'b0;
            if (set_v[i] || clr_v[i])
               arm[i] <= 1'b0;
            else if (stat_rd && flag[i])
               arm[i] <= 1'b1;
         end
      end
   end

   // Status writes reach no logic: read-only
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         tx_buffer_empty_o <= 1'b1;
      else if (ce_i)
         tx_buffer_empty_o <= set_v[scf_pkg::SCF_POS_TX_BUFFER_EMPTY] ||
            (flag[scf_pkg::SCF_POS_TX_BUFFER_EMPTY] && !clr_v[scf_pkg::SCF_POS_TX_BUFFER_EMPTY]);
   end

   // ****************************************************
   // Assertions
   // ****************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_rx_seen;
      ce_i && stat_rd && flag[scf_pkg::SCF_POS_RX_BUFFER_FULL] && !set_v[scf_pkg::SCF_POS_RX_BUFFER_FULL];
   endsequence

   sequence s_rx_taken;
      ce_i && data_rd && !stop_tick;
   endsequence

   a_tx_empty_set: assert property (ce_i && tx_load_i |=> flag[scf_pkg::SCF_POS_TX_BUFFER_EMPTY])
      else $error("buffer-empty flag missed its set");

   a_tx_empty_clear: assert property ($fell(flag[scf_pkg::SCF_POS_TX_BUFFER_EMPTY]) |->
      $past(data_wr && arm[scf_pkg::SCF_POS_TX_BUFFER_EMPTY]))
      else $error("buffer-empty flag cleared without its sequence");

   a_tx_done_clear: assert property ($fell(flag[scf_pkg::SCF_POS_TX_DONE]) |->
      $past(arm[scf_pkg::SCF_POS_TX_DONE] && (data_wr || te_rise || brk_wr)))
      else $error("done flag cleared without its sequence");

   a_rx_full_load: assert property (ce_i && char_load |=> flag[scf_pkg::SCF_POS_RX_BUFFER_FULL] &&
      !arm[scf_pkg::SCF_POS_RX_BUFFER_FULL])
      else $error("buffer-full flag missed a character");

   a_rx_full_clear: assert property (s_rx_seen ##1 s_rx_taken |=>
      !flag[scf_pkg::SCF_POS_RX_BUFFER_FULL])
      else $error("buffer-full flag survived its clear sequence");

   a_idle_once: assert property (ce_i && !idle_allow && !char_load && !flag[scf_pkg::SCF_POS_IDLE] |=>
      !flag[scf_pkg::SCF_POS_IDLE])
      else $error("idle flag set without a new character");

   a_overrun_drop: assert property (ce_i && overrun_set |=> flag[scf_pkg::SCF_POS_OVERRUN] &&
      $stable(rx_data_o))
      else $error("overrun did not keep the old character");

   a_noise_with_full: assert property ($rose(flag[scf_pkg::SCF_POS_NOISE_SEEN]) |->
      $past(char_load))
      else $error("noise flag set apart from a character");

   a_stop_error_set: assert property (ce_i && stop_tick && !bit_level && char_load |=>
      flag[scf_pkg::SCF_POS_STOP_BIT_ERROR] && flag[scf_pkg::SCF_POS_RX_BUFFER_FULL])
      else $error("stop-bit error missed");

endmodule : scf_status_flags

// File: scf_remote_node.sv
// Purpose: Remote serial node: receive bit ticks and transmitter shifter events
// Assumes: One tick per bit time, each tick two clocks apart
// Notes:   Tasks are called by the testbench

`timescale 1ns/10ps

module scf_remote_node (
   input  wire logic               clk_i,          // Clock
   output logic                    rx_bit_valid_o, // Bit time finished
   output scf_pkg::scf_rx_bit_type rx_bit_o,       // Bit kind and samples
   output logic                    tx_load_o,      // Word moved into shifter
   output logic                    tx_busy_o       // Shifter active
);
   initial
   begin
      rx_bit_valid_o = 1'b0;
      rx_bit_o       = '0;
      tx_load_o      = 1'b0;
      tx_busy_o      = 1'b0;
   end

   task automatic tick(input scf_pkg::scf_bit_kind_type k, input logic [6:0] s);
      @(posedge clk_i);
      rx_bit_valid_o <= 1'b1;
      rx_bit_o       <= '{k, s};
      @(posedge clk_i);
      rx_bit_valid_o <= 1'b0;
      // Stale samples are not held
      rx_bit_o       <= '{k, ~s};
   endtask : tick

   task automatic frame(input logic [8:0] d, input logic nine, input int noisy, input logic stop_ok);
      tick(scf_pkg::SCF_BIT_START, (noisy == 0) ? 7'h04 : 7'h00);
      for (int i = 0; i < (nine ? 9 : 8); i++)
      begin
         tick(scf_pkg::SCF_BIT_DATA, (noisy == i + 1) ? {4'h0, {2{d[i]}}, ~d[i]} : {4'h0, {3{d[i]}}});
      end
      tick(scf_pkg::SCF_BIT_STOP, stop_ok ? 7'h07 : 7'h00);
   endtask : frame

   task automatic idle(input int n);
      repeat (n) tick(scf_pkg::SCF_BIT_IDLE, 7'h7F);
   endtask : idle

   task automatic shift(input int n);
      @(posedge clk_i);
      tx_load_o <= 1'b1;
      tx_busy_o <= 1'b1;
      @(posedge clk_i);
      tx_load_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      tx_busy_o <= 1'b0;
   endtask : shift
endmodule : scf_remote_node

// File: testbench.sv
// Purpose: Self-checking bench for the serial status flag block
// Assumes: Clock enable high except for one freeze check, 20 MHz clock
// Notes:   Flags are seen through status and data reads and the buffer-empty pin

`timescale 1ns/10ps

module testbench;
   localparam logic [7:0] ST = scf_pkg::SCF_OFS_STATUS;
   localparam logic [7:0] DT = scf_pkg::SCF_OFS_DATA;
   localparam logic [7:0] C1 = scf_pkg::SCF_OFS_CTRL_ONE;
   localparam logic [7:0] C2 = scf_pkg::SCF_OFS_CTRL_TWO;
   localparam logic [7:0] IDLE_CTL [4] = '{8'h00, 8'h04, 8'h14, 8'h10};
   localparam int         IDLE_NEED [4] = '{1, 10, 11, 1};
   localparam logic [7:0] ERR_CTL [6] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h03, 8'h03};
   localparam logic [7:0] ERR_DAT [6] = '{8'h5A, 8'h5A, 8'h5A, 8'h01, 8'h01, 8'h03};
   localparam int         ERR_NOISE [6] = '{0, 4, -1, -1, -1, -1};
   localparam logic       ERR_STOP [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
   localparam logic [7:0] ERR_EXP [6] = '{8'h24, 8'h24, 8'h22, 8'h21, 8'h20, 8'h21};

   logic                     clk_i;
   logic                     rst_b_i;
   scf_pkg::scf_bus_req_type bus_i;
   logic [7:0]               rd_data_o;
   logic                     tx_load;
   logic                     tx_busy;
   logic                     rx_valid;
   scf_pkg::scf_rx_bit_type  rx_bit;
   logic [7:0]               tx_data_o;
   logic                     empty;
   logic                     tx_on_o;
   logic                     break_queue_o;
   logic                     preamble_req_o;
   logic                     ce;
   logic                     ninth;
   int                       fail_count = 0;
   int                       samples_checked = 0;
   int                       pre_count = 0;

   scf_status_flags DUT (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .bus_i(bus_i), .rd_data_o(rd_data_o),
      .tx_load_i(tx_load), .tx_busy_i(tx_busy), .rx_bit_valid_i(rx_valid), .rx_bit_i(rx_bit),
      .tx_data_o(tx_data_o), .tx_buffer_empty_o(empty), .tx_on_o(tx_on_o),
      .break_queue_o(break_queue_o), .preamble_req_o(preamble_req_o), .rx_data_o(),
      .rx_ninth_o(ninth)
   );

   scf_remote_node node (
      .clk_i(clk_i), .rx_bit_valid_o(rx_valid), .rx_bit_o(rx_bit), .tx_load_o(tx_load),
      .tx_busy_o(tx_busy)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   always @(posedge clk_i)
      if (preamble_req_o === 1'b1)
         pre_count <= pre_count + 1;

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus_i <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_i);
      bus_i <= '{a, d, 1'b0, 1'b0};
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
      @(posedge clk_i);
      bus_i <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_i);
      bus_i <= '{a, 8'h00, 1'b0, 1'b0};
      #1;
      chk($sformatf("addr %h", a), exp & m, rd_data_o & m);
   endtask : rd

   // Status read and data read with no gap between the strobes
   task automatic rd_pair(input logic [7:0] st_exp, input logic [7:0] dt_exp);
      @(posedge clk_i);
      bus_i <= '{ST, 8'h00, 1'b0, 1'b1};
      @(posedge clk_i);
      bus_i <= '{DT, 8'h00, 1'b0, 1'b1};
      #1;
      chk("status", st_exp & 8'h3F, rd_data_o & 8'h3F);
      @(posedge clk_i);
      bus_i <= '{DT, 8'h00, 1'b0, 1'b0};
      #1;
      chk("data", dt_exp, rd_data_o);
   endtask : rd_pair

   task automatic wrap_up;
      if (fail_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up

   initial
   begin
      #1_000_000;
      fail_count++;
      wrap_up();
   end

   // ****************************************************
   // Stimulus
   // ****************************************************
   initial
   begin
      rst_b_i = 1'b0;
      ce      = 1'b1;
      bus_i   = '0;
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      wr(DT, 8'h33);
      rd(ST, 8'hC0, 8'hFF);
      chk("empty pin", 8'h01, {7'h00, empty});
      wr(ST, 8'hFF);
      rd(ST, 8'hC0, 8'hFF);
      rd(8'h10, 8'h00, 8'hFF);
      // Data write while the clock enable is low must be ignored
      @(posedge clk_i);
      ce <= 1'b0;
      wr(DT, 8'h66);
      ce <= 1'b1;
      #1;
      chk("ce freeze", 8'h33, tx_data_o);
      wr(DT, 8'h44);
      rd(ST, 8'h00, 8'hFF);
      chk("tx data", 8'h44, tx_data_o);
      node.shift(4);
      wr(DT, 8'h55);
      rd(ST, 8'hC0, 8'hFF);
      wr(C2, 8'h08);
      rd(ST, 8'h80, 8'hFF);
      node.shift(3);
      rd(ST, 8'hC0, 8'hFF);
      wr(C2, 8'h09);
      rd(ST, 8'h80, 8'hFF);
      chk("tx controls", 8'h03, {6'h00, tx_on_o, break_queue_o});
      chk("preambles", 8'h01, pre_count[7:0]);
      node.frame(9'h05A, 1'b0, -1, 1'b1);
      rd(ST, 8'h20, 8'h3F);
      node.frame(9'h0A5, 1'b0, -1, 1'b1);
      rd(ST, 8'h28, 8'h3F);
      rd(DT, 8'h5A, 8'hFF);
      rd(ST, 8'h00, 8'h3F);
      for (int i = 0; i < 4; i++)
      begin
         wr(C1, IDLE_CTL[i]);
         node.frame(9'h1FF, IDLE_CTL[i][4], -1, 1'b1);
         node.idle(IDLE_NEED[i] - 1);
         rd(ST, 8'h20, 8'h30);
         chk("ninth", {7'h00, IDLE_CTL[i][4]}, {7'h00, ninth});
         node.idle(1);
         rd(ST, 8'h30, 8'h30);
         rd(DT, 8'hFF, 8'hFF);
         node.idle(12);
         rd(ST, 8'h00, 8'h30);
      end
      for (int i = 0; i < 6; i++)
      begin
         wr(C1, ERR_CTL[i]);
         node.frame({1'b0, ERR_DAT[i]}, 1'b0, ERR_NOISE[i], ERR_STOP[i]);
         rd_pair(ERR_EXP[i], ERR_DAT[i]);
         rd(ST, 8'h00, 8'h3F);
      end
      wrap_up();
   end
endmodule : testbench
